// ==== vac_pkg.sv ====
// Shared constants, types and register layout for the band search controller.
`default_nettype none

package vac_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [5:0] ADDR_INT = 6'h03;
   localparam logic [5:0] ADDR_FRAC = 6'h04;
   localparam logic [5:0] ADDR_CP = 6'h09;
   localparam logic [5:0] ADDR_CFG = 6'h0a;
   localparam logic [5:0] ADDR_BAND = 6'h15;
   localparam logic [5:0] ADDR_ODIV = 6'h16;
   localparam logic [5:0] ADDR_OCFG = 6'h17;

   // ==========================================================================
   // Field positions
   localparam int CFG_N_LSB = 0;
   localparam int CFG_DIS_BIT = 11;
   localparam int CFG_M_LSB = 13;
   localparam int CFG_RELOCK_BIT = 17;
   localparam int BAND_LSB = 1;
   localparam int ODIV_LSB = 0;
   localparam int GAIN_LSB = 6;
   localparam int OCFG_MUTE_BIT = 7;
   localparam int CP_DN_LSB = 0;
   localparam int CP_UP_LSB = 7;
   localparam int CP_OFF_LSB = 14;
   localparam int CP_UPOFF_BIT = 21;
   localparam int CP_DNOFF_BIT = 22;
   localparam int FRAC_BITS = 24;

   // ==========================================================================
   // Reset values and cycle counts
   localparam logic [23:0] REG_RST = 24'h000000;
   localparam logic [7:0] LINK_BITS = 8'h10;
   localparam logic [7:0] LINK_TICKS = 8'h14;
   localparam logic [7:0] SETTLE_TICKS = 8'h80;

   // ==========================================================================
   // Types
   typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_SEND, ST_MEASURE, ST_DECIDE,
                             ST_LAST_SEND, ST_LOAD} vac_state_type;

   typedef struct packed {
      logic dn_off_en;
      logic up_off_en;
      logic [6:0] offset;
      logic [6:0] up_gain;
      logic [6:0] dn_gain;
   } vac_cp_type;

endpackage : vac_pkg

`default_nettype wire

// ==== vac_band_search.sv ====
// Oscillator band search, divider loading, mute and charge pump control.
//
// Overview of operation
// - Division ratio is integer word plus fractional word over two to the 24.
// - Search machine clock is reference period times 1, 4, 16 or 32 for m of 0 to 3, m from bits 14:13.
// - Each measurement expects floor of ratio times 2^n counts and compares.
// - Five-bit search: up to six measurements, seven 20-tick link transfers.
// - Worst-case search time is 6R*2^n reference plus 268 search machine clock periods.
// - Search clock also clocks the 16-bit oscillator link; accuracy unaffected.
// - Once band is chosen the pending fractional word goes to the modulator.
// - Chosen band is readable in band register bits 8:1 after every search.
// - With search disabled a host band write reaches the oscillator at once.
// - Fractional mode: fractional write starts search, word applied after it.
// - Search disabled: fractional write applied at once, band unchanged.
// - Integer mode: integer write starts search; with search disabled the prescaler loads at once.
// - Outputs stay muted while the output divider field is zero.
// - Mute-during-search bit mutes outputs during frequency-change searches.
// - Output gain comes from divider register bits 10:6.
// - Pump up gain from bits 13:7, down gain from bits 6:0.
// - Pump offset from bits 20:14; bit 21 up offset, bit 22 down offset.
// - Measurement length exponent n from configuration bits 2:0.
// - Search enabled: every write of the mode's frequency word starts a search, same value too.
// - Auto-relock bit: on unlock, rerun search and relock only once.
`timescale 1ns/1ps
`default_nettype none

module vac_band_search
   import vac_pkg::*;
#(
   parameter int BAND_BITS = 5
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Main serial port register access
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [5:0] i_reg_addr,
   input wire logic [23:0] i_reg_wdata,
   output logic [23:0] o_reg_rdata,
   // Loop status and timing pulses
   input wire logic i_frac_mode,
   input wire logic i_ref_tick,
   input wire logic i_pd_tick,
   input wire logic i_vco_tick,
   input wire logic i_locked,
   // Divider and oscillator controls
   output logic [23:0] o_int_div,
   output logic [23:0] o_frac_div,
   output logic [7:0] o_band,
   output logic o_tune_hold,
   output logic o_cal_busy,
   // Internal oscillator serial link
   output logic o_link_clk_en,
   output logic o_link_sel,
   output logic o_link_data,
   // Output stage and charge pump
   output logic o_mute,
   output logic [5:0] o_out_div,
   output logic [4:0] o_out_gain,
   output vac_cp_type o_cp
);

   // ==========================================================================
   // Search machine clock divider
   logic [4:0] div_r, div_nxt, div_lim;
   logic fsm_tick_r, fsm_tick_nxt;
   logic [23:0] cfg_r;

   always_comb
   begin
      case (cfg_r[CFG_M_LSB +: 2])
         2'h0: div_lim = 5'h00;
         2'h1: div_lim = 5'h03;
         2'h2: div_lim = 5'h0f;
         default: div_lim = 5'h1f;
      endcase
      div_nxt = div_r;
      fsm_tick_nxt = 1'b0;
      if (i_ref_tick)
      begin
         if (div_r >= div_lim)
         begin
            div_nxt = 5'h00;
            fsm_tick_nxt = 1'b1;
         end
         else
         begin
            div_nxt = div_r + 5'h01;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         div_r <= 5'h00;
         fsm_tick_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         fsm_tick_r <= fsm_tick_nxt;
      end
   end

   // ==========================================================================
   // Registers, band search machine and outputs
   vac_state_type st_r, st_nxt;
   logic [23:0] int_r, int_nxt, frac_r, frac_nxt, cp_r, cp_nxt, cfg_nxt;
   logic [23:0] band_r, band_nxt, odiv_r, odiv_nxt, ocfg_r, ocfg_nxt;
   logic [23:0] int_act_r, int_act_nxt, frac_act_r, frac_act_nxt, rdata_r, rdata_nxt;
   logic [7:0] band_act_r, band_act_nxt, trial_r, trial_nxt, tick_r, tick_nxt;
   logic [2:0] bit_r, bit_nxt, n_exp;
   logic [15:0] shift_r, shift_nxt;
   logic [31:0] meas_r, meas_nxt, target;
   logic [8:0] pd_r, pd_nxt, meas_len;
   logic last_r, last_nxt, freq_cal_r, freq_cal_nxt, used_r, used_nxt;
   logic lock_d_r, mute_r, mute_nxt, sel_r, sel_nxt, sdata_r, sdata_nxt;
   logic clk_en_r, clk_en_nxt, busy_r, busy_nxt;
   logic cal_dis, host_start, relock_start;
   logic [55:0] scaled;
   logic [7:0] band_max;

   always_comb
   begin
      n_exp = cfg_r[CFG_N_LSB +: 3];
      cal_dis = cfg_r[CFG_DIS_BIT];
      scaled = {8'h00, int_r, frac_r} << n_exp;
      target = scaled[FRAC_BITS +: 32];
      meas_len = 9'h001 << n_exp;
      band_max = 8'((9'h001 << BAND_BITS) - 9'h001);
      int_nxt = int_r;
      frac_nxt = frac_r;
      cp_nxt = cp_r;
      cfg_nxt = cfg_r;
      band_nxt = band_r;
      odiv_nxt = odiv_r;
      ocfg_nxt = ocfg_r;
      int_act_nxt = int_act_r;
      frac_act_nxt = frac_act_r;
      band_act_nxt = band_act_r;
      rdata_nxt = rdata_r;
      st_nxt = st_r;
      trial_nxt = trial_r;
      tick_nxt = tick_r;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      meas_nxt = meas_r;
      pd_nxt = pd_r;
      last_nxt = last_r;
      freq_cal_nxt = freq_cal_r;
      used_nxt = used_r;
      sel_nxt = 1'b0;
      sdata_nxt = 1'b0;
      clk_en_nxt = 1'b0;
      host_start = 1'b0;
      if (i_reg_wr)
      begin
         if (i_reg_addr == ADDR_INT)
         begin
            int_nxt = i_reg_wdata;
            if (cal_dis)
               int_act_nxt = i_reg_wdata;
            else if (!i_frac_mode)
               host_start = 1'b1;
         end
         else if (i_reg_addr == ADDR_FRAC)
         begin
            frac_nxt = i_reg_wdata;
            if (cal_dis)
               frac_act_nxt = i_reg_wdata;
            else if (i_frac_mode)
               host_start = 1'b1;
         end
         else if (i_reg_addr == ADDR_CP)
            cp_nxt = i_reg_wdata;
         else if (i_reg_addr == ADDR_CFG)
            cfg_nxt = i_reg_wdata;
         else if (i_reg_addr == ADDR_BAND)
         begin
            band_nxt = i_reg_wdata;
            if (cal_dis)
               band_act_nxt = i_reg_wdata[BAND_LSB +: 8];
         end
         else if (i_reg_addr == ADDR_ODIV)
            odiv_nxt = i_reg_wdata;
         else if (i_reg_addr == ADDR_OCFG)
            ocfg_nxt = i_reg_wdata;
      end
      if (i_reg_rd)
      begin
         if (i_reg_addr == ADDR_INT)
            rdata_nxt = int_r;
         else if (i_reg_addr == ADDR_FRAC)
            rdata_nxt = frac_r;
         else if (i_reg_addr == ADDR_CP)
            rdata_nxt = cp_r;
         else if (i_reg_addr == ADDR_CFG)
            rdata_nxt = cfg_r;
         else if (i_reg_addr == ADDR_BAND)
            rdata_nxt = band_r;
         else if (i_reg_addr == ADDR_ODIV)
            rdata_nxt = odiv_r;
         else if (i_reg_addr == ADDR_OCFG)
            rdata_nxt = ocfg_r;
         else
            rdata_nxt = REG_RST;
      end
      relock_start = cfg_r[CFG_RELOCK_BIT] && lock_d_r && !i_locked && !used_r
                     && (st_r == ST_IDLE) && !cal_dis;
      if (host_start)
         used_nxt = 1'b0;
      else if (relock_start)
         used_nxt = 1'b1;
      case (st_r)
         ST_IDLE:
         begin
         end
         ST_SETTLE:
         begin
            if (fsm_tick_r)
            begin
               tick_nxt = tick_r + 8'h01;
               if (tick_r == SETTLE_TICKS - 8'h01)
               begin
                  bit_nxt = 3'(BAND_BITS - 1);
                  trial_nxt = 8'h01 << (BAND_BITS - 1);
                  shift_nxt = {8'h00, 8'h01 << (BAND_BITS - 1)};
                  tick_nxt = 8'h00;
                  st_nxt = ST_SEND;
               end
            end
         end
         ST_SEND, ST_LAST_SEND:
         begin
            if (fsm_tick_r)
            begin
               tick_nxt = tick_r + 8'h01;
               if (tick_r < LINK_BITS)
               begin
                  sel_nxt = 1'b1;
                  clk_en_nxt = 1'b1;
                  sdata_nxt = shift_r[15];
                  shift_nxt = {shift_r[14:0], 1'b0};
               end
               if (tick_r == LINK_TICKS - 8'h01)
               begin
                  band_act_nxt = trial_r;
                  meas_nxt = 32'h00000000;
                  pd_nxt = 9'h000;
                  st_nxt = (st_r == ST_LAST_SEND) ? ST_LOAD : ST_MEASURE;
               end
            end
         end
         ST_MEASURE:
         begin
            if (i_vco_tick && (pd_r != 9'h000))
               meas_nxt = meas_r + 32'h00000001;
            if (i_pd_tick)
            begin
               pd_nxt = pd_r + 9'h001;
               if (pd_r == meas_len)
                  st_nxt = ST_DECIDE;
            end
         end
         ST_DECIDE:
         begin
            tick_nxt = 8'h00;
            if (last_r)
            begin
               if ((meas_r > target) && (trial_r != band_max))
                  trial_nxt = trial_r + 8'h01;
               shift_nxt = {8'h00, trial_nxt};
               st_nxt = ST_LAST_SEND;
            end
            else
            begin
               if (meas_r < target)
                  trial_nxt[bit_r] = 1'b0;
               if (bit_r == 3'h0)
                  last_nxt = 1'b1;
               else
               begin
                  bit_nxt = bit_r - 3'h1;
                  trial_nxt[bit_r - 3'h1] = 1'b1;
               end
               shift_nxt = {8'h00, trial_nxt};
               st_nxt = ST_SEND;
            end
         end
         ST_LOAD:
         begin
            band_nxt[BAND_LSB +: 8] = trial_r;
            int_act_nxt = int_r;
            frac_act_nxt = frac_r;
            freq_cal_nxt = 1'b0;
            st_nxt = ST_IDLE;
         end
         default:
            st_nxt = ST_IDLE;
      endcase
      if (host_start || relock_start)
      begin
         st_nxt = ST_SETTLE;
         tick_nxt = 8'h00;
         last_nxt = 1'b0;
         freq_cal_nxt = host_start;
      end
      mute_nxt = (odiv_r[ODIV_LSB +: 6] == 6'h00)
                 || (ocfg_r[OCFG_MUTE_BIT] && freq_cal_r);
      busy_nxt = (st_nxt != ST_IDLE);
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         int_r <= REG_RST;
         frac_r <= REG_RST;
         cp_r <= REG_RST;
         cfg_r <= REG_RST;
         band_r <= REG_RST;
         odiv_r <= REG_RST;
         ocfg_r <= REG_RST;
         int_act_r <= REG_RST;
         frac_act_r <= REG_RST;
         rdata_r <= REG_RST;
         band_act_r <= 8'h00;
         st_r <= ST_IDLE;
         trial_r <= 8'h00;
         tick_r <= 8'h00;
         bit_r <= 3'h0;
         shift_r <= 16'h0000;
         meas_r <= 32'h00000000;
         pd_r <= 9'h000;
         last_r <= 1'b0;
         freq_cal_r <= 1'b0;
         used_r <= 1'b0;
         lock_d_r <= 1'b0;
         mute_r <= 1'b1;
         sel_r <= 1'b0;
         sdata_r <= 1'b0;
         clk_en_r <= 1'b0;
         busy_r <= 1'b0;
      end
      else
      begin
         int_r <= int_nxt;
         frac_r <= frac_nxt;
         cp_r <= cp_nxt;
         cfg_r <= cfg_nxt;
         band_r <= band_nxt;
         odiv_r <= odiv_nxt;
         ocfg_r <= ocfg_nxt;
         int_act_r <= int_act_nxt;
         frac_act_r <= frac_act_nxt;
         rdata_r <= rdata_nxt;
         band_act_r <= band_act_nxt;
         st_r <= st_nxt;
         trial_r <= trial_nxt;
         tick_r <= tick_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
         meas_r <= meas_nxt;
         pd_r <= pd_nxt;
         last_r <= last_nxt;
         freq_cal_r <= freq_cal_nxt;
         used_r <= used_nxt;
         lock_d_r <= i_locked;
         mute_r <= mute_nxt;
         sel_r <= sel_nxt;
         sdata_r <= sdata_nxt;
         clk_en_r <= clk_en_nxt;
         busy_r <= busy_nxt;
      end
   end

   // ==========================================================================
   // Output assignments straight from flip-flops
   assign o_reg_rdata = rdata_r;
   assign o_int_div = int_act_r;
   assign o_frac_div = frac_act_r;
   assign o_band = band_act_r;
   assign o_tune_hold = busy_r;
   assign o_cal_busy = busy_r;
   assign o_link_clk_en = clk_en_r;
   assign o_link_sel = sel_r;
   assign o_link_data = sdata_r;
   assign o_mute = mute_r;
   assign o_out_div = odiv_r[ODIV_LSB +: 6];
   assign o_out_gain = odiv_r[GAIN_LSB +: 5];
   assign o_cp = {cp_r[CP_DNOFF_BIT], cp_r[CP_UPOFF_BIT], cp_r[CP_OFF_LSB +: 7],
                  cp_r[CP_UP_LSB +: 7], cp_r[CP_DN_LSB +: 7]};

endmodule : vac_band_search

`default_nettype wire

// ==== vac_band_search_monitor.sv ====
// Port checker for the band search controller.
`timescale 1ns/1ps
`default_nettype none

module vac_mon
   import vac_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Register access and mode
   input wire logic i_reg_wr,
   input wire logic [5:0] i_reg_addr,
   input wire logic [23:0] i_reg_wdata,
   input wire logic i_frac_mode,
   // Observed outputs
   input wire logic [23:0] o_frac_div,
   input wire logic [7:0] o_band,
   input wire logic o_cal_busy,
   input wire logic o_mute,
   input wire logic [5:0] o_out_div,
   input wire logic [4:0] o_out_gain,
   input wire vac_cp_type o_cp
);
   // ==========================================================================
   // Shadow copies of the configuration registers
   logic [47:0] sh_r;
   logic [47:0] sh_nxt;
   wire logic dis = sh_r[CFG_DIS_BIT];
   wire logic cmute = sh_r[24 + OCFG_MUTE_BIT];
   wire logic wr_f = i_reg_wr && i_reg_addr == ADDR_FRAC;

   always_comb
   begin
      sh_nxt = sh_r;
      if (i_reg_wr && i_reg_addr == ADDR_CFG) sh_nxt[23:0] = i_reg_wdata;
      if (i_reg_wr && i_reg_addr == ADDR_OCFG) sh_nxt[47:24] = i_reg_wdata;
   end

   always_ff @(posedge i_clock or negedge i_resetn)
      if (!i_resetn) sh_r <= '0;
      else sh_r <= sh_nxt;

   // ==========================================================================
   // Assertions
   default clocking mc @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   frac_start_a:
   assert property (wr_f && i_frac_mode && !dis |=> o_cal_busy)
      else $error("fractional write did not start a search");
   int_start_a:
   assert property (i_reg_wr && i_reg_addr == ADDR_INT && !i_frac_mode && !dis |=> o_cal_busy)
      else $error("integer write did not start a search");
   band_manual_a:
   assert property (i_reg_wr && i_reg_addr == ADDR_BAND && dis
      |=> o_band == $past(i_reg_wdata[8:1])) else $error("manual band not applied");
   frac_direct_a:
   assert property (wr_f && dis |=> o_frac_div == $past(i_reg_wdata) && $stable(o_band))
      else $error("direct fractional write wrong");
   frac_pending_a:
   assert property (o_cal_busy ##1 o_cal_busy |-> $stable(o_frac_div))
      else $error("fractional word changed during search");
   search_bound_a:
   assert property ($rose(o_cal_busy) |-> ##[1:1000] !o_cal_busy)
      else $error("search took too long");
   div_mute_a:
   assert property ((o_out_div == 6'h00) [*2] |-> o_mute) else $error("zero divider not muted");
   cal_mute_a:
   assert property (cmute && o_cal_busy && $past(o_cal_busy) |-> o_mute)
      else $error("search not muted");
   mute_release_a:
   assert property ($fell(o_cal_busy) && o_out_div != 6'h00 |=> ##1 !o_mute)
      else $error("mute held after search");
   gain_field_a:
   assert property (i_reg_wr && i_reg_addr == ADDR_ODIV |=> o_out_gain == $past(i_reg_wdata[10:6]))
      else $error("output gain wrong");
   cp_field_a:
   assert property (i_reg_wr && i_reg_addr == ADDR_CP |=> o_cp == $past(i_reg_wdata[22:0]))
      else $error("pump fields wrong");

   search_c: cover property ($rose(o_cal_busy));
   muted_c: cover property (o_cal_busy && o_mute);
   manual_c: cover property (i_reg_wr && dis);
endmodule : vac_mon

bind vac_band_search vac_mon mon (.i_clock, .i_resetn, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
   .i_frac_mode, .o_frac_div, .o_band, .o_cal_busy, .o_mute, .o_out_div, .o_out_gain, .o_cp);

`default_nettype wire

// ==== vac_host_model.sv ====
// Host and oscillator model facing the band search controller.
`timescale 1ns/1ps
`default_nettype none

module vac_host_model
(
   // Clock, reset, observed band and read data
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [7:0] i_band,
   input wire logic [23:0] i_rdata,
   // Register access and loop ticks
   output logic o_wr,
   output logic o_rd,
   output logic [5:0] o_addr,
   output logic [23:0] o_wdata,
   output logic o_ref_tick,
   output logic o_pd_tick,
   output logic o_vco_tick
);
   logic [4:0] ph_r;

   initial
   begin
      {o_wr, o_rd, o_addr, o_wdata, o_pd_tick, o_vco_tick} = '0;
      ph_r = 5'h00;
   end

   // Search clock equals the bench clock, well under its ceiling.
   assign o_ref_tick = 1'b1;

   // Oscillator runs slower as the band code rises.
   always @(posedge i_clock)
   begin
      ph_r <= ph_r + 5'h01;
      o_pd_tick <= ph_r == 5'h00;
      o_vco_tick <= i_resetn && ph_r < 5'h1f - i_band[4:0];
   end

   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge i_clock);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [23:0] d);
      @(posedge i_clock);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(negedge i_clock);
      d = i_rdata;
   endtask : rd
endmodule : vac_host_model

`default_nettype wire

// ==== vac_band_search_tb_top.sv ====
// Self-checking bench for the band search controller.
`timescale 1ns/1ps
`default_nettype none

module vac_band_search_tb_top
   import vac_pkg::*;
;
   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   logic fmode = 1'b1;
   logic locked = 1'b1;
   logic wr, rd, reft, pdt, vcot, hold, busy, lclk, lsel, ldat, mute;
   logic [5:0] addr, odiv;
   logic [23:0] wdata, rdata, idiv, fdiv, d, r15, iv, fv;
   logic [7:0] band;
   logic [15:0] lword = 16'h0000;
   logic [4:0] gain;
   vac_cp_type cp;
   int n_mismatch = 0;
   int checks_done = 0;
   int lcnt = 0;
   int nn = 0;

   always #50 i_clock = ~i_clock;
   always @(posedge i_clock)
   begin
      if (lclk === 1'b1 && lsel === 1'b1)
      begin
         lcnt <= lcnt + 1;
         lword <= {lword[14:0], ldat};
      end
   end

   vac_host_model host (.i_clock, .i_resetn, .i_band(band), .i_rdata(rdata), .o_wr(wr),
      .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .o_ref_tick(reft), .o_pd_tick(pdt),
      .o_vco_tick(vcot));

   vac_band_search dut (.i_clock, .i_resetn, .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_frac_mode(fmode), .i_ref_tick(reft),
      .i_pd_tick(pdt), .i_vco_tick(vcot), .i_locked(locked), .o_int_div(idiv),
      .o_frac_div(fdiv), .o_band(band), .o_tune_hold(hold), .o_cal_busy(busy),
      .o_link_clk_en(lclk), .o_link_sel(lsel), .o_link_data(ldat), .o_mute(mute),
      .o_out_div(odiv), .o_out_gain(gain), .o_cp(cp));

   task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic print_verdict;
      if (n_mismatch == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic wait_busy(input logic lv, input int lim);
      int k;
      k = 0;
      while (busy !== lv && k < lim)
      begin
         @(negedge i_clock);
         k++;
      end
      if (busy !== lv)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask : wait_busy

   // Successive search over the oscillator model, integers only.
   function automatic int exp_band(input logic [23:0] i, input logic [23:0] f, input int n);
      longint t;
      int b;
      t = longint'({i, f});
      t = (t << n) >> 24;
      b = 0;
      for (int s = 4; s >= 0; s--)
      begin
         b = b | (1 << s);
         if (longint'((31 - b) << n) < t) b = b & ~(1 << s);
      end
      if (longint'((31 - b) << n) > t && b != 31) b++;
      return b;
   endfunction : exp_band

   task automatic freq(input logic [5:0] a, input logic [23:0] v, input logic me);
      int b;
      lcnt = 0;
      host.wr(a, v);
      @(negedge i_clock);
      cmp("busy", 24'h1, {23'h0, busy});
      cmp("hold", 24'h1, {23'h0, hold});
      @(negedge i_clock);
      cmp("mute_cal", {23'h0, me}, {23'h0, mute});
      wait_busy(1'b0, 3000);
      b = exp_band(iv, fv, nn);
      cmp("band", 24'(b), {16'h0, band});
      cmp("frac", fv, fdiv);
      cmp("int", iv, idiv);
      cmp("link", 24'h70, 24'(lcnt));
      cmp("link_word", 24'(b), {8'h0, lword});
      r15 = (r15 & 24'hfffe01) | 24'(b << 1);
      host.rd(ADDR_BAND, d);
      cmp("band_reg", r15, d);
      @(negedge i_clock);
      cmp("mute_end", 24'h0, {23'h0, mute});
   endtask : freq

   initial
   begin
      void'($urandom(39008));
      r15 = 24'h0;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      @(negedge i_clock);
      cmp("mute_rst", 24'h1, {23'h0, mute});
      for (int i = 0; i < 8; i++)
      begin
         host.rd(6'(i == 7 ? 63 : i == 6 ? 3 : i + 4), d);
         cmp("reset_read", 24'h0, d);
      end
      d = {13'h0, 5'($urandom), 6'($urandom_range(63, 1))};
      host.wr(ADDR_ODIV, d);
      repeat (2) @(negedge i_clock);
      cmp("gain", {19'h0, d[10:6]}, {19'h0, gain});
      cmp("mute_div", 24'h0, {23'h0, mute});
      d = 24'($urandom);
      host.wr(ADDR_CP, d);
      @(negedge i_clock);
      cmp("cp", {1'b0, d[22:0]}, {1'b0, cp});
      // Host picks n = 1 and a ratio well above the fractional floor.
      nn = 1;
      host.wr(ADDR_OCFG, 24'h000080);
      host.wr(ADDR_CFG, 24'h000001);
      iv = 24'h000014;
      fv = 24'h800000;
      host.wr(ADDR_INT, iv);
      repeat (2) @(negedge i_clock);
      cmp("int_pend", 24'h0, idiv);
      freq(ADDR_FRAC, fv, 1'b1);
      freq(ADDR_FRAC, fv, 1'b1);
      host.wr(ADDR_OCFG, 24'h000000);
      host.wr(ADDR_CFG, 24'h020000);
      @(posedge i_clock) fmode <= 1'b0;
      nn = 0;
      repeat (3)
      begin
         iv = 24'($urandom_range(27, 20));
         freq(ADDR_INT, iv, 1'b0);
      end
      @(posedge i_clock) locked <= 1'b0;
      wait_busy(1'b1, 10);
      cmp("relock", 24'h1, {23'h0, busy});
      wait_busy(1'b0, 3000);
      @(posedge i_clock) locked <= 1'b1;
      repeat (3) @(posedge i_clock);
      locked <= 1'b0;
      repeat (10) @(negedge i_clock);
      cmp("relock_once", 24'h0, {23'h0, busy});
      host.wr(ADDR_CFG, 24'h000800);
      d = 24'($urandom);
      host.wr(ADDR_BAND, d);
      @(negedge i_clock);
      cmp("band_man", {16'h0, d[8:1]}, {16'h0, band});
      fv = 24'($urandom);
      host.wr(ADDR_FRAC, fv);
      @(negedge i_clock);
      cmp("frac_now", fv, fdiv);
      cmp("band_kept", {16'h0, d[8:1]}, {16'h0, band});
      iv = 24'($urandom_range(40, 16));
      host.wr(ADDR_INT, iv);
      @(negedge i_clock);
      cmp("int_now", iv, idiv);
      cmp("idle", 24'h0, {23'h0, busy});
      host.wr(ADDR_ODIV, 24'h000000);
      repeat (3) @(negedge i_clock);
      cmp("mute_zero", 24'h1, {23'h0, mute});
      print_verdict();
   end
endmodule : vac_band_search_tb_top

`default_nettype wire
